// ===== rtl/acl_pkg.sv
// Constants and types shared by the codec-side link port
package acl_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BITCLK_PERIOD_PS = 81400;
  localparam int BITCLK_HALF_CYC = BITCLK_PERIOD_PS / 2 / CLK_PERIOD_PS;
  localparam int COLD_RESET_MIN_PS = 1000000;
  localparam int WARM_SYNC_MIN_PS = 1000000;
  localparam int STARTUP_PS = 162800;
  localparam int STARTUP_CYC = (STARTUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PDOWN_MAX_PS = 1000000;
  localparam int PDOWN_MAX_CYC = PDOWN_MAX_PS / CLK_PERIOD_PS;
  localparam int ATE_OFF_PS = 25000;
  localparam int ATE_OFF_CYC = ATE_OFF_PS / CLK_PERIOD_PS;
  localparam int FRAME_BITS = 256;
  localparam int TAG_BITS = 16;
  localparam int SLOT_BITS = 20;
  localparam logic [7:0] SLOT2_LAST_BIT = 8'(TAG_BITS + 2 * SLOT_BITS - 1);
  localparam int PIN_RESET = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_DOUT = 2;
  localparam int PIN_COUNT = 3;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_START,
    ST_RUN,
    ST_PDOWN,
    ST_WARM,
    ST_ATE
  } acl_state_t;

  typedef struct packed {
    logic level;
    logic [3:0] cnt;
  } acl_gen_t;

  typedef struct packed {
    acl_state_t state;
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic rstPrev;
    logic syncPrev;
    logic [5:0] cnt;
    logic [7:0] bitIdx;
    logic pdPending;
    logic sdataIn;
    logic rxBit;
    logic rxValid;
    logic rxSync;
    logic frameStart;
  } acl_link_t;
endpackage

// ===== rtl/acl_bitclk_gen.sv
// Bit clock divider with edge strobes
`timescale 1ns/1ps
module acl_bitclk_gen (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic bitClk,
  output logic risePulse,
  output logic fallPulse
);
  acl_pkg::acl_gen_t st;
  acl_pkg::acl_gen_t next_st;
  logic halfDone;

  assign halfDone = st.cnt == 4'(acl_pkg::BITCLK_HALF_CYC - 1);
  assign risePulse = run && halfDone && !st.level;
  assign fallPulse = run && halfDone && st.level;
  assign bitClk = st.level;

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.level = 1'b0;
      next_st.cnt = 4'h0;
    end else if (halfDone) begin
      next_st.level = !st.level; // R4
      next_st.cnt = 4'h0;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // A link reset may stop the clock in mid phase
  a_high_phase: assert property (@(posedge sys_clk) disable iff (sys_rst || !run) // R4
    $rose(bitClk) |-> bitClk [*8] ##1 !bitClk)
    else $error("bit clock high phase wrong length");
endmodule

// ===== rtl/acl_codec_link.sv
// Codec-side serial link port: resets, framing, power-down and test mode
// Contract
// R1 - A cold reset holds the reset pin low at least 1.0 us and the bit clock starts no sooner than 162.8 ns after.
// R2 - A warm reset is a sync pulse of at least 1.0 us sent while the bit clock is stopped.
// R3 - After the warm-reset sync falls the bit clock restarts no sooner than 162.8 ns later.
// R4 - The bit clock runs near 12.288 MHz with each phase within a 45/55 split.
// R5 - The controller sends sync at 48 kHz, high about 1.3 us and low about 19.5 us.
// R6 - Link data is sampled on the falling bit clock edge and launched on the rising edge.
// R7 - On power-down the bit clock and input data go low within 1.0 us after slot 2 ends.
// R8 - For normal start the controller keeps sync and output data low through reset release.
// R9 - Output data high at reset release puts every link output into high impedance within 25 ns.
// R10 - Test mode holds until another reset with all link signals low restores normal operation.
// R11 - A frame is 256 bit clocks with sync high for the first 16, launched on a rising edge.
// R12 - While powered down the input data stays low and traffic is ignored until a reset.
`timescale 1ns/1ps
module acl_codec_link (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic resetN,
  input wire logic syncPin,
  input wire logic sdataOutPin,
  output logic bitClk,
  output logic bitClkOeN,
  output logic sdataIn,
  output logic sdataInOeN,
  input wire logic txBit,
  output logic txReady,
  output logic rxBit,
  output logic rxValid,
  output logic rxSync,
  output logic frameStart,
  output logic [7:0] bitIndex,
  input wire logic pdReq,
  output logic poweredDown,
  output logic testMode
);
  acl_pkg::acl_link_t st;
  acl_pkg::acl_link_t next_st;
  logic run;
  logic risePulse;
  logic fallPulse;
  logic rstRise;
  logic syncS;
  logic doutS;
  logic [7:0] nextIdx;

  assign run = st.state == acl_pkg::ST_RUN;
  assign syncS = st.s2[acl_pkg::PIN_SYNC];
  assign doutS = st.s2[acl_pkg::PIN_DOUT];
  assign rstRise = st.s2[acl_pkg::PIN_RESET] && !st.rstPrev;
  assign nextIdx = (syncS && !st.syncPrev) ? 8'h00 : st.bitIdx + 8'h01;

  acl_bitclk_gen u_gen (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(run),
    .bitClk(bitClk),
    .risePulse(risePulse),
    .fallPulse(fallPulse)
  );

  always_comb begin
    next_st = st;
    next_st.s1[acl_pkg::PIN_RESET] = resetN;
    next_st.s1[acl_pkg::PIN_SYNC] = syncPin;
    next_st.s1[acl_pkg::PIN_DOUT] = sdataOutPin;
    next_st.s2 = st.s1;
    next_st.rstPrev = st.s2[acl_pkg::PIN_RESET];
    next_st.rxValid = 1'b0;
    next_st.frameStart = 1'b0;
    case (st.state)
      acl_pkg::ST_RESET: begin
        if (rstRise) begin
          if (doutS) begin
            next_st.state = acl_pkg::ST_ATE; // R9
          end else begin
            next_st.state = acl_pkg::ST_START; // R1
            next_st.cnt = 6'h00;
          end
        end
      end
      acl_pkg::ST_START: begin
        if (st.cnt == 6'(acl_pkg::STARTUP_CYC - 1)) begin
          next_st.state = acl_pkg::ST_RUN; // R1 R3
          next_st.syncPrev = 1'b0;
          next_st.bitIdx = 8'hff;
        end else begin
          next_st.cnt = st.cnt + 6'h01;
        end
      end
      acl_pkg::ST_RUN: begin
        next_st.pdPending = st.pdPending | pdReq;
        if (risePulse) begin
          next_st.sdataIn = txBit; // R6
        end
        if (fallPulse) begin
          next_st.rxBit = doutS; // R6
          next_st.rxValid = 1'b1;
          next_st.rxSync = syncS;
          next_st.syncPrev = syncS;
          next_st.bitIdx = nextIdx; // R11
          next_st.frameStart = syncS && !st.syncPrev;
          if (st.pdPending && nextIdx == acl_pkg::SLOT2_LAST_BIT) begin
            next_st.state = acl_pkg::ST_PDOWN; // R7
            next_st.pdPending = pdReq;
          end
        end
      end
      acl_pkg::ST_PDOWN: begin
        if (syncS) begin
          next_st.state = acl_pkg::ST_WARM; // R12
        end
      end
      acl_pkg::ST_WARM: begin
        if (!syncS) begin
          next_st.state = acl_pkg::ST_START; // R3
          next_st.cnt = 6'h00;
        end
      end
      acl_pkg::ST_ATE: begin
        if (rstRise && !doutS && !syncS) begin
          next_st.state = acl_pkg::ST_START; // R10
          next_st.cnt = 6'h00;
        end
      end
      default: begin
        next_st.state = acl_pkg::ST_RESET;
      end
    endcase
    // Held reset sends every state but test mode back to reset, clearing the counter and pending power-down
    if (!st.s2[acl_pkg::PIN_RESET] && st.state != acl_pkg::ST_ATE) begin
      next_st.state = acl_pkg::ST_RESET;
      next_st.cnt = 6'h00;
      next_st.pdPending = 1'b0;
    end
    if (next_st.state != acl_pkg::ST_RUN) begin
      next_st.sdataIn = 1'b0; // R7 R12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign txReady = risePulse && run;
  assign sdataIn = st.sdataIn;
  assign rxBit = st.rxBit;
  assign rxValid = st.rxValid;
  assign rxSync = st.rxSync;
  assign frameStart = st.frameStart;
  assign bitIndex = st.bitIdx;
  assign poweredDown = st.state == acl_pkg::ST_PDOWN || st.state == acl_pkg::ST_WARM;
  assign testMode = st.state == acl_pkg::ST_ATE;
  assign bitClkOeN = testMode; // R9
  assign sdataInOeN = testMode; // R9

  sequence s_start_wait;
    st.state == acl_pkg::ST_START && st.cnt != 6'(acl_pkg::STARTUP_CYC - 1);
  endsequence
  sequence s_ate_request;
    rstRise && doutS && st.state == acl_pkg::ST_RESET;
  endsequence

  a_start_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
    (s_start_wait and st.s2[acl_pkg::PIN_RESET]) |=> st.state == acl_pkg::ST_START && !bitClk)
    else $error("bit clock started before the startup delay");
  a_run_entry: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
    $rose(st.state == acl_pkg::ST_RUN) |-> $past(st.cnt) == 6'(acl_pkg::STARTUP_CYC - 1))
    else $error("run entered without full startup count");
  a_warm_restart: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
    st.state == acl_pkg::ST_WARM && !syncS && st.s2[acl_pkg::PIN_RESET]
      |=> st.state == acl_pkg::ST_START && st.cnt == 6'h00)
    else $error("warm reset did not restart the clock");
  a_rx_on_fall: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
    rxValid |-> $past(fallPulse) && $past(run))
    else $error("data sampled off the falling edge");
  a_tx_on_rise: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
    run && $past(run) && $changed(sdataIn) |-> $past(risePulse))
    else $error("input data changed off the rising edge");
  a_pdown_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7 R12
    poweredDown |-> !bitClk && !sdataIn)
    else $error("link not quiet while powered down");
  a_pdown_slot2: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
    $rose(st.state == acl_pkg::ST_PDOWN) |-> st.bitIdx == acl_pkg::SLOT2_LAST_BIT)
    else $error("power-down not at end of slot 2");
  a_ate_hiz: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
    s_ate_request |=> bitClkOeN && sdataInOeN)
    else $error("test mode did not release the link outputs");
  a_ate_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
    testMode && !(rstRise && !doutS && !syncS) |=> testMode)
    else $error("test mode left without a clean reset");
  a_frame_start: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
    frameStart |-> bitIndex == 8'h00 && rxSync)
    else $error("frame start not aligned to index zero");
endmodule

// ===== dv/acl_ctrl_model.sv
// Behavioural link controller: reset sequences, frame sync and serial data
`timescale 1ns/1ps
module acl_ctrl_model (
  input wire logic sys_clk,
  input wire logic bitClk,
  output logic resetN,
  output logic syncPin,
  output logic sdataOutPin
);
  logic clkPrev = 1'b0;
  logic [7:0] cnt = 8'h00;
  initial begin
    resetN = 1'b0;
    syncPin = 1'b0;
    sdataOutPin = 1'b0;
  end
  // Launch on the rising bit clock, sync high for the tag slot, quiet in reset
  always @(posedge sys_clk) begin
    clkPrev <= bitClk;
    if (resetN && bitClk && !clkPrev) begin
      syncPin <= (cnt < 8'h10);
      sdataOutPin <= cnt[0] ^ cnt[2];
      cnt <= cnt + 8'h01;
    end
  end
  task automatic cold(input logic ate);
    @(posedge sys_clk);
    resetN <= 1'b0;
    // Launcher is gated off from here, so these are not overwritten
    @(posedge sys_clk);
    syncPin <= 1'b0;
    sdataOutPin <= ate;
    cnt <= 8'h00;
    repeat (200) @(posedge sys_clk);
    resetN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sdataOutPin <= 1'b0;
  endtask
  task automatic warm();
    @(posedge sys_clk);
    syncPin <= 1'b1;
    sdataOutPin <= 1'b0;
    cnt <= 8'h00;
    repeat (200) @(posedge sys_clk);
    syncPin <= 1'b0;
  endtask
endmodule

// ===== dv/test_ac_link_reset_lowpower_test.sv
// Self-checking bench for the codec-side link port
`timescale 1ns/1ps
module test_ac_link_reset_lowpower_test;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic txBit = 1'b0;
  logic pdReq = 1'b0;
  logic resetN, syncPin, sdataOutPin, bitClk, bitClkOeN, sdataIn, sdataInOeN, txReady;
  logic rxBit, rxValid, rxSync, frameStart, poweredDown, testMode;
  logic [7:0] bitIndex;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  // Bit to send, frame index of that bit
  localparam logic [8:0] ROWS [5] = '{9'h101, 9'h00f, 9'h110, 9'h1ff, 9'h000};
  always #2.5 sys_clk = ~sys_clk;
  acl_ctrl_model ctrl (.sys_clk(sys_clk), .bitClk(bitClk), .resetN(resetN), .syncPin(syncPin),
    .sdataOutPin(sdataOutPin));
  acl_codec_link DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .resetN(resetN), .syncPin(syncPin),
    .sdataOutPin(sdataOutPin), .bitClk(bitClk), .bitClkOeN(bitClkOeN), .sdataIn(sdataIn),
    .sdataInOeN(sdataInOeN), .txBit(txBit), .txReady(txReady), .rxBit(rxBit), .rxValid(rxValid),
    .rxSync(rxSync), .frameStart(frameStart), .bitIndex(bitIndex), .pdReq(pdReq),
    .poweredDown(poweredDown), .testMode(testMode));
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait: 0 txReady, 1 sample at index, 2 powered down, 3 bit clock high
  task automatic wait_for(input int sel, input logic [7:0] idx, output int cyc);
    cyc = 0;
    while (!(sel == 0 ? txReady === 1'b1 : sel == 1 ? (rxValid === 1'b1 && bitIndex === idx) :
             sel == 2 ? poweredDown === 1'b1 : bitClk === 1'b1)) begin
      tick();
      cyc++;
      if (cyc > 5000) begin
        n_mismatch++;
        close_out();
      end
    end
  endtask
  initial begin
    repeat (4) tick();
    check(8'(bitClk), 8'h00);
    @(posedge sys_clk) sys_rst <= 1'b0;
    ctrl.cold(1'b0);
    wait_for(3, 8'h00, n);
    check(8'(n + 4 >= acl_pkg::STARTUP_CYC), 8'h01);
    for (n = 0; n < 40 && bitClk === 1'b1; n++) tick();
    check(8'(n), 8'(acl_pkg::BITCLK_HALF_CYC));
    for (n = 0; n < 40 && bitClk === 1'b0; n++) tick();
    check(8'(n), 8'(acl_pkg::BITCLK_HALF_CYC));
    $display("test cold start done");
    for (int i = 0; i < 5; i++) begin
      wait_for(1, ROWS[i][7:0] - 8'h01, n);
      @(posedge sys_clk) txBit <= ROWS[i][8];
      wait_for(0, 8'h00, n);
      tick();
      check(8'(sdataIn), 8'(ROWS[i][8]));
      wait_for(1, ROWS[i][7:0], n);
      check(8'(rxBit), 8'(ROWS[i][0] ^ ROWS[i][2]));
      check(8'({rxSync, frameStart}), {6'h00, ROWS[i][7:4] == 4'h0, ROWS[i][7:0] == 8'h00});
    end
    $display("test frame rows done");
    @(posedge sys_clk) pdReq <= 1'b1;
    @(posedge sys_clk) pdReq <= 1'b0;
    wait_for(2, 8'h00, n);
    check(bitIndex, 8'h37);
    check(8'({bitClk, sdataIn}), 8'h00);
    n = 0;
    repeat (100) begin
      tick();
      if ((bitClk | rxValid | sdataIn | !poweredDown) !== 1'b0) n++;
    end
    check(8'(n), 8'h00);
    ctrl.warm();
    wait_for(3, 8'h00, n);
    check(8'(n >= acl_pkg::STARTUP_CYC), 8'h01);
    $display("test power down and warm reset done");
    ctrl.cold(1'b1);
    tick();
    check({5'h00, testMode, bitClkOeN, sdataInOeN}, 8'h07);
    ctrl.cold(1'b0);
    tick();
    check({5'h00, testMode, bitClkOeN, sdataInOeN}, 8'h00);
    wait_for(3, 8'h00, n);
    check(8'(bitClk), 8'h01);
    $display("test high impedance mode done");
    close_out();
  end
endmodule
